// ### rtl/port_ext_interrupt_and_pin_mux.sv
// Port external interrupt detection and special function pin multiplexer.
// Summary of operation
// - Each pin has enable, flag, edge select.
// - Edge select picks rising or falling detection.
// - Select 0 rising edge, 1 falling edge.
// - Valid selected edge sets the pin flag.
// - Request needs flag, enable, mask, global enable.
// - Enable 1 detects edges, 0 disables.
// - Valid edge triggers clock switchback in power mode.
// - Reset disables special functions except JTAG.
// - Special function overrides direction and output.
// - Interrupt inputs leave pin drive unchanged.
// - Direction 1 drives output value, 0 input.
// - Pin 0 drives TDO, output after reset.
// - Pins 1-3 are JTAG inputs with pullup.
// - Interrupt n is pin n, per enable.
// - Pin 4 starts ADC for select 100/101.
// - Pin 5 loads DAC for 000/100/101.
// - Pins 6,7 drive timer outputs when enabled.
// - Pins 6,7 count in counter mode.
// - Pins 6,7 gate timers when gating selected.
// - Pins 4-7 reset as pullup inputs.
`default_nettype none
module port_ext_interrupt_and_pin_mux (
  // Clock and reset.
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // Port pins: output enable is low while the pin is driven.
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] PIN_I,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] PIN_OUT_O,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] PIN_OE_N_O,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] PIN_PULLUP_O,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] PIN_IN_O,
  // Standard port settings.
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] PORT_DIRECTION_I,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] PORT_OUTPUT_I,
  // External interrupt settings and status.
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] EXT_INT_ENABLE_I,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] EXT_INT_EDGE_SELECT_I,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] EXT_INT_FLAG_CLEAR_I,
  input wire pin_mux_pkg::int_ctrl_s INT_CTRL_I,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] EXT_INT_FLAG_O,
  output logic INT_REQ_O,
  output logic SWITCHBACK_O,
  // JTAG port enable and signals.
  input wire logic JTAG_ENABLE_WRITE_I,
  input wire logic JTAG_ENABLE_DATA_I,
  output logic JTAG_ENABLE_O,
  input wire logic JTAG_TDO_I,
  output logic JTAG_TMS_O,
  output logic JTAG_TDI_O,
  output logic JTAG_TCK_O,
  // Neighbouring block settings and pin functions.
  input wire pin_mux_pkg::special_cfg_s SPECIAL_CFG_I,
  input wire logic [1:0] TIMER_OUT_I,
  output logic ADC_CONVERT_START_O,
  output logic DAC_LOAD_O,
  output logic [1:0] TIMER_COUNT_IN_O,
  output logic [1:0] TIMER_GATE_IN_O
);
  import pin_mux_pkg::*;

  // Synchronised pin levels and edge pulses.
  logic [PIN_COUNT-1:0] level_w;
  logic [PIN_COUNT-1:0] rise_w;
  logic [PIN_COUNT-1:0] fall_w;
  // Interrupt state.
  logic [PIN_COUNT-1:0] flag_q;
  logic [PIN_COUNT-1:0] flag_d;
  logic [PIN_COUNT-1:0] edge_hit;
  logic irq_q;
  logic irq_d;
  logic switchback_q;
  logic switchback_d;
  // JTAG port enable, set at reset.
  logic jtag_enable_q;
  logic jtag_enable_d;
  // Special function claims per pin.
  logic adc_active;
  logic dac_active;
  logic timer_count_active;
  logic timer_gate_active;
  logic [PIN_COUNT-1:0] spec_out_en;
  logic [PIN_COUNT-1:0] spec_out_val;
  logic [PIN_COUNT-1:0] spec_in_en;
  pin_mode_e pin_mode [PIN_COUNT];
  // Pin drive next values and registers.
  logic [PIN_COUNT-1:0] pin_out_d;
  logic [PIN_COUNT-1:0] pin_oe_n_d;
  logic [PIN_COUNT-1:0] pin_pullup_d;
  logic [PIN_COUNT-1:0] pin_out_q;
  logic [PIN_COUNT-1:0] pin_oe_n_q;
  logic [PIN_COUNT-1:0] pin_pullup_q;
  logic [PIN_COUNT-1:0] pin_in_q;
  // Function input registers.
  logic tms_q;
  logic tdi_q;
  logic tck_q;
  logic adc_start_q;
  logic dac_load_q;
  logic [1:0] count_in_q;
  logic [1:0] gate_in_q;
  logic tms_d;
  logic tdi_d;
  logic tck_d;
  logic adc_start_d;
  logic dac_load_d;
  logic [1:0] count_in_d;
  logic [1:0] gate_in_d;

  // Every pin is synchronised before any edge is judged.
  pin_input_sync #(
    .WIDTH(PIN_COUNT)
  ) u_pin_sync (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .pin_i(PIN_I),
    .level_o(level_w),
    .rise_o(rise_w),
    .fall_o(fall_w)
  );

  // Interrupt detection: pin n feeds interrupt n, all eight alike.
  always_comb begin
    // Select 0 takes rising edges, 1 falling edges; disabled pins are ignored.
    edge_hit = EXT_INT_ENABLE_I & ((EXT_INT_EDGE_SELECT_I & fall_w) |
               (~EXT_INT_EDGE_SELECT_I & rise_w));
    // A new edge wins over a clear in the same cycle, so no event is lost.
    flag_d = (flag_q & ~EXT_INT_FLAG_CLEAR_I) | edge_hit;
    // Flagged and enabled pins request only when both global gates are open.
    irq_d = (|(flag_q & EXT_INT_ENABLE_I)) & INT_CTRL_I.module0_int_mask &
            INT_CTRL_I.global_int_enable;
    // Any valid edge in power management mode asks the clock control to leave the slow rate.
    switchback_d = (|edge_hit) & INT_CTRL_I.power_mgmt_mode_enable;
  end

  // JTAG port enable is the one special function alive after reset.
  always_comb begin
    jtag_enable_d = JTAG_ENABLE_WRITE_I ? JTAG_ENABLE_DATA_I : jtag_enable_q;
  end

  // Which neighbouring functions own their pins right now.
  always_comb begin
    adc_active = (SPECIAL_CFG_I.adc_start_source_sel == ADC_SEL_PIN_A) ||
                 (SPECIAL_CFG_I.adc_start_source_sel == ADC_SEL_PIN_B);
    dac_active = (SPECIAL_CFG_I.dac_load_source_sel == DAC_SEL_PIN_A) ||
                 (SPECIAL_CFG_I.dac_load_source_sel == DAC_SEL_PIN_B) ||
                 (SPECIAL_CFG_I.dac_load_source_sel == DAC_SEL_PIN_C);
    timer_count_active = SPECIAL_CFG_I.counter_timer_select &&
                         (SPECIAL_CFG_I.capture_compare_function != CCF_NONE) &&
                         !SPECIAL_CFG_I.timer_output_enable;
    timer_gate_active = (SPECIAL_CFG_I.gate_enable ||
                         ((SPECIAL_CFG_I.capture_compare_function == CCF_CAPTURE) &&
                          SPECIAL_CFG_I.capture_reload_select)) &&
                        !SPECIAL_CFG_I.timer_output_enable &&
                        !SPECIAL_CFG_I.counter_timer_select;
    // Output claims: TDO on pin 0, timer outputs on pins 6 and 7.
    spec_out_en = '0;
    spec_out_val = '0;
    spec_out_en[PIN_TDO] = jtag_enable_q;
    spec_out_val[PIN_TDO] = JTAG_TDO_I;
    spec_out_en[PIN_TIMER0] = SPECIAL_CFG_I.timer_output_enable;
    spec_out_en[PIN_TIMER1] = SPECIAL_CFG_I.timer_output_enable;
    spec_out_val[PIN_TIMER0] = TIMER_OUT_I[0];
    spec_out_val[PIN_TIMER1] = TIMER_OUT_I[1];
    // Input claims hold the pin as a pulled-up input.
    spec_in_en = '0;
    spec_in_en[PIN_TMS] = jtag_enable_q;
    spec_in_en[PIN_TDI] = jtag_enable_q;
    spec_in_en[PIN_TCK] = jtag_enable_q;
    spec_in_en[PIN_ADC_START] = adc_active;
    spec_in_en[PIN_DAC_LOAD] = dac_active;
    spec_in_en[PIN_TIMER0] = timer_count_active || timer_gate_active;
    spec_in_en[PIN_TIMER1] = timer_count_active || timer_gate_active;
  end

  // Per-pin drive; interrupt inputs never appear here, so they leave the pin alone.
  generate
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
      // Output claims outrank input claims on the same pin.
      assign pin_mode[i] = spec_out_en[i] ? MODE_SPECIAL_OUT :
                           spec_in_en[i] ? MODE_SPECIAL_IN : MODE_STANDARD;
      // Standard mode: direction 1 drives the output bit, 0 makes it an input, pulled up only when the output bit is 1.
      assign pin_out_d[i] = (pin_mode[i] == MODE_SPECIAL_OUT) ? spec_out_val[i] :
                            (pin_mode[i] == MODE_STANDARD) ? PORT_OUTPUT_I[i] :
                            1'b0;
      assign pin_oe_n_d[i] = (pin_mode[i] == MODE_SPECIAL_OUT) ? 1'b0 :
                             (pin_mode[i] == MODE_STANDARD) ? ~PORT_DIRECTION_I[i] :
                             1'b1;
      // The pullup follows the output bit on standard inputs and is on for claimed inputs.
      assign pin_pullup_d[i] = (pin_mode[i] == MODE_SPECIAL_IN) ? 1'b1 :
                               (pin_mode[i] == MODE_STANDARD) ?
                               (~PORT_DIRECTION_I[i] & PORT_OUTPUT_I[i]) : 1'b0;
    end
  endgenerate

  // Inputs handed to the neighbours; idle values when not claimed.
  always_comb begin
    tms_d = jtag_enable_q ? level_w[PIN_TMS] : 1'b1;
    tdi_d = jtag_enable_q ? level_w[PIN_TDI] : 1'b1;
    tck_d = jtag_enable_q ? level_w[PIN_TCK] : 1'b0;
    adc_start_d = adc_active & level_w[PIN_ADC_START];
    dac_load_d = dac_active & level_w[PIN_DAC_LOAD];
    count_in_d = {2{timer_count_active}} & level_w[PIN_TIMER1:PIN_TIMER0];
    gate_in_d = {2{timer_gate_active}} & level_w[PIN_TIMER1:PIN_TIMER0];
  end

  // All state registers; reset leaves JTAG live and pins 1 to 7 pulled-up inputs.
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      flag_q <= FLAG_RESET;
      irq_q <= 1'b0;
      switchback_q <= 1'b0;
      jtag_enable_q <= JTAG_ENABLE_RESET;
      pin_out_q <= PIN_OUT_RESET;
      pin_oe_n_q <= PIN_OE_N_RESET;
      pin_pullup_q <= PIN_PULLUP_RESET;
      pin_in_q <= '1;
      tms_q <= 1'b1;
      tdi_q <= 1'b1;
      tck_q <= 1'b0;
      adc_start_q <= 1'b0;
      dac_load_q <= 1'b0;
      count_in_q <= 2'h0;
      gate_in_q <= 2'h0;
    end else begin
      flag_q <= flag_d;
      irq_q <= irq_d;
      switchback_q <= switchback_d;
      jtag_enable_q <= jtag_enable_d;
      pin_out_q <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
      pin_pullup_q <= pin_pullup_d;
      pin_in_q <= level_w;
      tms_q <= tms_d;
      tdi_q <= tdi_d;
      tck_q <= tck_d;
      adc_start_q <= adc_start_d;
      dac_load_q <= dac_load_d;
      count_in_q <= count_in_d;
      gate_in_q <= gate_in_d;
    end
  end

  // Every output comes straight from a register.
  assign PIN_OUT_O = pin_out_q;
  assign PIN_OE_N_O = pin_oe_n_q;
  assign PIN_PULLUP_O = pin_pullup_q;
  assign PIN_IN_O = pin_in_q;
  assign EXT_INT_FLAG_O = flag_q;
  assign INT_REQ_O = irq_q;
  assign SWITCHBACK_O = switchback_q;
  assign JTAG_ENABLE_O = jtag_enable_q;
  assign JTAG_TMS_O = tms_q;
  assign JTAG_TDI_O = tdi_q;
  assign JTAG_TCK_O = tck_q;
  assign ADC_CONVERT_START_O = adc_start_q;
  assign DAC_LOAD_O = dac_load_q;
  assign TIMER_COUNT_IN_O = count_in_q;
  assign TIMER_GATE_IN_O = gate_in_q;

  // Checks on the interrupt path and the pin drive.
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  property p_flag_set;
    (|edge_hit) |=> ((flag_q & $past(edge_hit)) == $past(edge_hit));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Edge did not set its flag.");

  property p_fall_ignored_on_rise_select;
    (fall_w[0] && !rise_w[0] && !EXT_INT_EDGE_SELECT_I[0] && !flag_q[0]) |=> !flag_q[0];
  endproperty
  a_fall_ignored_on_rise_select: assert property (p_fall_ignored_on_rise_select)
    else $error("Falling edge flagged with rising select.");

  property p_flag_sticky;
    1'b1 |=> (($past(flag_q) & ~$past(EXT_INT_FLAG_CLEAR_I) & ~flag_q) == '0);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("Flag dropped without clear.");

  property p_no_flag_when_disabled;
    1'b1 |=> ((flag_q & ~$past(flag_q) & ~$past(EXT_INT_ENABLE_I)) == '0);
  endproperty
  a_no_flag_when_disabled: assert property (p_no_flag_when_disabled)
    else $error("Flag set on disabled pin.");

  property p_irq_gating;
    ((|(flag_q & EXT_INT_ENABLE_I)) && INT_CTRL_I.module0_int_mask &&
     INT_CTRL_I.global_int_enable) |=> INT_REQ_O;
  endproperty
  a_irq_gating: assert property (p_irq_gating) else $error("Request missing.");

  property p_irq_blocked;
    !INT_CTRL_I.global_int_enable |=> !INT_REQ_O;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked) else $error("Request with gate closed.");

  property p_switchback;
    ((|edge_hit) && INT_CTRL_I.power_mgmt_mode_enable) |=> SWITCHBACK_O;
  endproperty
  a_switchback: assert property (p_switchback) else $error("Switchback not raised.");

  property p_tdo_drive;
    jtag_enable_q |=> (!PIN_OE_N_O[PIN_TDO] && (PIN_OUT_O[PIN_TDO] == $past(JTAG_TDO_I)));
  endproperty
  a_tdo_drive: assert property (p_tdo_drive) else $error("TDO not driven.");

  property p_timer_out;
    SPECIAL_CFG_I.timer_output_enable |=>
      ((PIN_OE_N_O[7:6] == 2'h0) && (PIN_OUT_O[7:6] == $past(TIMER_OUT_I)));
  endproperty
  a_timer_out: assert property (p_timer_out) else $error("Timer output not driven.");

  property p_standard_pin4;
    !adc_active |=> ((PIN_OE_N_O[4] == !$past(PORT_DIRECTION_I[4])) &&
                     (PIN_OUT_O[4] == $past(PORT_OUTPUT_I[4])));
  endproperty
  a_standard_pin4: assert property (p_standard_pin4) else $error("Pin 4 drive wrong.");

  property p_adc_claim;
    adc_active |=> (PIN_OE_N_O[4] && PIN_PULLUP_O[4] &&
                    (ADC_CONVERT_START_O == $past(level_w[4])));
  endproperty
  a_adc_claim: assert property (p_adc_claim) else $error("ADC pin claim wrong.");

  c_flag_and_request: cover property (edge_hit[0] ##1 flag_q[0] ##1 INT_REQ_O);
  c_switchback: cover property (SWITCHBACK_O);
  c_jtag_released: cover property (jtag_enable_q ##1 !jtag_enable_q);
  c_gate_claim: cover property (timer_gate_active);
endmodule : port_ext_interrupt_and_pin_mux
`default_nettype wire

// ### rtl/pin_mux_pkg.sv
// Shared constants and carrier types for the port interrupt and pin multiplexer.
`default_nettype none
package pin_mux_pkg;
  // Number of port pins.
  localparam int PIN_COUNT = 8;
  // Pin positions of the special functions.
  localparam int PIN_TDO = 0;
  localparam int PIN_TMS = 1;
  localparam int PIN_TDI = 2;
  localparam int PIN_TCK = 3;
  localparam int PIN_ADC_START = 4;
  localparam int PIN_DAC_LOAD = 5;
  localparam int PIN_TIMER0 = 6;
  localparam int PIN_TIMER1 = 7;
  // Source select codes that hand a pin to the ADC or the DAC.
  localparam logic [2:0] ADC_SEL_PIN_A = 3'h4;
  localparam logic [2:0] ADC_SEL_PIN_B = 3'h5;
  localparam logic [2:0] DAC_SEL_PIN_A = 3'h0;
  localparam logic [2:0] DAC_SEL_PIN_B = 3'h4;
  localparam logic [2:0] DAC_SEL_PIN_C = 3'h5;
  // Capture/compare function codes.
  localparam logic [1:0] CCF_NONE = 2'h0;
  localparam logic [1:0] CCF_CAPTURE = 2'h3;
  // Reset values.
  localparam logic JTAG_ENABLE_RESET = 1'b1;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] PIN_OUT_RESET = 8'h00;
  localparam logic [7:0] PIN_OE_N_RESET = 8'hFE;
  localparam logic [7:0] PIN_PULLUP_RESET = 8'hFE;
  // Depth of the pin synchroniser.
  localparam int SYNC_STAGES = 2;

  // Per-pin drive mode, one-hot.
  typedef enum logic [2:0] {
    MODE_STANDARD = 3'b001,
    MODE_SPECIAL_OUT = 3'b010,
    MODE_SPECIAL_IN = 3'b100
  } pin_mode_e;

  // Settings of the neighbouring blocks that claim pins.
  typedef struct packed {
    logic [2:0] adc_start_source_sel;
    logic [2:0] dac_load_source_sel;
    logic timer_output_enable;
    logic counter_timer_select;
    logic [1:0] capture_compare_function;
    logic gate_enable;
    logic capture_reload_select;
  } special_cfg_s;

  // Global interrupt gating and power mode.
  typedef struct packed {
    logic module0_int_mask;
    logic global_int_enable;
    logic power_mgmt_mode_enable;
  } int_ctrl_s;
endpackage : pin_mux_pkg
`default_nettype wire

// ### rtl/pin_input_sync.sv
// Two-stage pin synchroniser with registered edge pulses.
`default_nettype none
module pin_input_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Raw pins and conditioned results.
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);
  // The first stage may go metastable; only the second stage reads it.
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] rise_q;
  logic [WIDTH-1:0] fall_q;
  logic [WIDTH-1:0] rise_d;
  logic [WIDTH-1:0] fall_d;

  // A zero-width chain cannot be built, so it is refused while elaborating.
  if (WIDTH < 1) begin : g_width_check
    $error("pin_input_sync needs at least one pin.");
  end

  // Edges are judged on the clean second stage only.
  always_comb begin
    rise_d = stable_q & ~prev_q;
    fall_d = ~stable_q & prev_q;
  end

  // Pins idle high through the weak pullups, so the chain resets high.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '1;
      stable_q <= '1;
      prev_q <= '1;
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      meta_q <= pin_i;
      stable_q <= meta_q;
      prev_q <= stable_q;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign level_o = stable_q;
  assign rise_o = rise_q;
  assign fall_o = fall_q;
endmodule : pin_input_sync
`default_nettype wire

// ### tb/pin_board_model.sv
// Board-side model of the port pads as seen from outside the device.
`default_nettype none
module pin_board_model (
  // Clock.
  input wire logic clk_i,
  // Device side of the pads.
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_n_i,
  input wire logic [7:0] pullup_i,
  // Board drivers.
  input wire logic [7:0] drive_en_i,
  input wire logic [7:0] drive_val_i,
  // Resolved pad levels.
  output logic [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A pad that nobody holds toggles every cycle, so a floating read never matches by luck.
  logic [7:0] float_q = 8'h00;
  always @(posedge clk_i) float_q <= ~float_q;
  // The device driver wins, then the board driver, then the weak pullup.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n_i[i]) pin_o[i] = out_i[i];
      else if (drive_en_i[i]) pin_o[i] = drive_val_i[i];
      else if (pullup_i[i]) pin_o[i] = 1'b1;
      else pin_o[i] = float_q[i];
    end
  end
endmodule : pin_board_model
`default_nettype wire

// ### tb/port_ext_interrupt_and_pin_mux_bench.sv
// Self-checking bench for the port interrupt and pin multiplexer.
`default_nettype none
module port_ext_interrupt_and_pin_mux_bench import pin_mux_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, jwr, jdat, jen, tdo, tms, tdi, tck, int_req, switchback, adc_o, dac_o;
  logic [7:0] pin, pin_out, pin_oe_n, pin_pullup, pin_in, dir, outv, ext_en, edge_sel;
  logic [7:0] flag_clr, flag, drv_en, drv_val;
  logic [1:0] tmr_out, cnt_o, gate_o;
  int_ctrl_s ictl;
  special_cfg_s cfg;
  int miscompares, tests_run;

  port_ext_interrupt_and_pin_mux u_port_ext_interrupt_and_pin_mux (
    .CLOCK_I(clk), .RST_N_I(rst_n), .PIN_I(pin), .PIN_OUT_O(pin_out),
    .PIN_OE_N_O(pin_oe_n), .PIN_PULLUP_O(pin_pullup), .PIN_IN_O(pin_in),
    .PORT_DIRECTION_I(dir), .PORT_OUTPUT_I(outv), .EXT_INT_ENABLE_I(ext_en),
    .EXT_INT_EDGE_SELECT_I(edge_sel), .EXT_INT_FLAG_CLEAR_I(flag_clr), .INT_CTRL_I(ictl),
    .EXT_INT_FLAG_O(flag), .INT_REQ_O(int_req), .SWITCHBACK_O(switchback),
    .JTAG_ENABLE_WRITE_I(jwr), .JTAG_ENABLE_DATA_I(jdat), .JTAG_ENABLE_O(jen),
    .JTAG_TDO_I(tdo), .JTAG_TMS_O(tms), .JTAG_TDI_O(tdi), .JTAG_TCK_O(tck),
    .SPECIAL_CFG_I(cfg), .TIMER_OUT_I(tmr_out), .ADC_CONVERT_START_O(adc_o),
    .DAC_LOAD_O(dac_o), .TIMER_COUNT_IN_O(cnt_o), .TIMER_GATE_IN_O(gate_o));

  pin_board_model u_pin_board_model (
    .clk_i(clk), .out_i(pin_out), .oe_n_i(pin_oe_n), .pullup_i(pin_pullup),
    .drive_en_i(drv_en), .drive_val_i(drv_val), .pin_o(pin));

  // Free-running 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  // Lets edges pass and steps clear of the edge so outputs have settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Pins 0 to 3 belong to the JTAG port until it is switched off.
  task automatic jtag_case();
    @(posedge clk);
    dir <= 8'hFF;
    outv <= 8'hFF;
    tdo <= 1'b1;
    drv_en <= 8'h0E;
    drv_val <= 8'h0A;
    tick(5);
    check(pin_oe_n, 8'h0E);
    check(pin_out, 8'hF1);
    check(pin_pullup, 8'h0E);
    check(8'({tms, tdi, tck}), 8'h05);
    @(posedge clk);
    tdo <= 1'b0;
    drv_val <= 8'h04;
    tick(5);
    check(pin_out, 8'hF0);
    check(8'({tms, tdi, tck}), 8'h02);
    @(posedge clk);
    jwr <= 1'b1;
    jdat <= 1'b0;
    @(posedge clk);
    jdat <= 1'b1;
    #1;
    check(8'(jen), 8'h00);
    @(posedge clk);
    jdat <= 1'b0;
    #1;
    check(8'(jen), 8'h01);
    @(posedge clk);
    jwr <= 1'b0;
    tick(2);
    check(8'({jen, tms, tdi, tck}), 8'h06);
    check(pin_oe_n, 8'h00);
    check(pin_out, 8'hFF);
  endtask : jtag_case

  // Standard drive, with and without interrupt enables on every pin.
  task automatic standard_case();
    for (int e = 0; e < 2; e++) begin
      @(posedge clk);
      dir <= 8'hAA;
      outv <= 8'h0F;
      ext_en <= {8{e[0]}};
      drv_en <= 8'hFF;
      drv_val <= 8'h00;
      tick(4);
      check(pin_oe_n, 8'h55);
      check(pin_out, 8'h0F);
      check(pin_pullup, 8'h05);
      check(pin_in, 8'h0A);
    end
  endtask : standard_case

  // One edge of either polarity on one pin, then the opposite edge.
  task automatic edge_case(input int p, input logic pol, input logic en, input logic pwr);
    int sw;
    int first;
    @(posedge clk);
    edge_sel[p] <= pol;
    ext_en[p] <= en;
    ictl.power_mgmt_mode_enable <= pwr;
    drv_val[p] <= pol;
    tick(6);
    @(posedge clk);
    flag_clr <= 8'hFF;
    @(posedge clk);
    flag_clr <= 8'h00;
    @(posedge clk);
    drv_val[p] <= ~pol;
    sw = 0;
    first = 0;
    for (int k = 1; k <= 8; k++) begin
      tick(1);
      sw += int'(switchback);
      if (flag[p] === 1'b1 && first == 0) first = k;
    end
    check(8'(first), en ? 8'h04 : 8'h00);
    check(8'(sw), (en && pwr) ? 8'h01 : 8'h00);
    check(flag, en ? (8'h01 << p) : 8'h00);
    @(posedge clk);
    flag_clr <= 8'hFF;
    @(posedge clk);
    flag_clr <= 8'h00;
    drv_val[p] <= pol;
    tick(8);
    check(flag, 8'h00);
  endtask : edge_case

  // Request gating by enable, module mask and global enable; sticky flag.
  task automatic gate_case();
    @(posedge clk);
    ext_en <= 8'h04;
    edge_sel <= 8'h00;
    drv_val[2] <= 1'b0;
    tick(5);
    @(posedge clk);
    drv_val[2] <= 1'b1;
    tick(6);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      ext_en[2] <= i[0];
      ictl.module0_int_mask <= i[1];
      ictl.global_int_enable <= i[2];
      tick(3);
      check(8'(int_req), 8'(i == 7));
    end
    check(flag, 8'h04);
    @(posedge clk);
    flag_clr <= 8'h04;
    @(posedge clk);
    flag_clr <= 8'h00;
    tick(3);
    check(8'({flag[2], int_req}), 8'h00);
  endtask : gate_case

  // Every source select code for the converter start and load pins.
  task automatic adc_dac_case();
    logic a;
    logic d;
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      dir <= 8'hFF;
      outv <= 8'h00;
      drv_val <= 8'hFF;
      cfg.adc_start_source_sel <= 3'(s);
      cfg.dac_load_source_sel <= 3'(s);
      tick(5);
      a = (s == 4 || s == 5);
      d = (s == 0 || a);
      check(8'({adc_o, dac_o, pin_oe_n[5:4]}), 8'({a, d, d, a}));
    end
  endtask : adc_dac_case

  // Every combination of the timer settings that claim pins 6 and 7.
  task automatic timer_case();
    logic [1:0] oe;
    logic [1:0] ov;
    logic [1:0] cn;
    logic [1:0] gt;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      dir <= 8'h00;
      drv_val <= 8'hC0;
      tmr_out <= 2'h1;
      cfg.dac_load_source_sel <= 3'h1;
      {cfg.timer_output_enable, cfg.counter_timer_select} <= 2'(i >> 4);
      cfg.capture_compare_function <= 2'(i >> 2);
      {cfg.gate_enable, cfg.capture_reload_select} <= 2'(i);
      tick(5);
      oe = i[5] ? 2'h0 : 2'h3;
      ov = i[5] ? 2'h1 : 2'h0;
      cn = (i[4] && i[3:2] != 2'h0 && !i[5]) ? 2'h3 : 2'h0;
      gt = (!i[5] && !i[4] && (i[1] || (i[3:2] == 2'h3 && i[0]))) ? 2'h3 : 2'h0;
      check({pin_oe_n[7:6], pin_out[7:6], cnt_o, gate_o}, {oe, ov, cn, gt});
    end
  endtask : timer_case

  // Main sequence: reset, then each scenario in turn.
  initial begin
    rst_n = 1'b0;
    {jwr, jdat, tdo} = 3'h0;
    {dir, outv, ext_en, edge_sel, flag_clr, drv_en, drv_val} = '0;
    tmr_out = 2'h0;
    ictl = '0;
    cfg = '0;
    cfg.dac_load_source_sel = 3'h1;
    miscompares = 0;
    tests_run = 0;
    tick(3);
    check(pin_oe_n, 8'hFE);
    check(pin_pullup, 8'hFE);
    check(pin_out, 8'h00);
    check(flag, 8'h00);
    check(8'({jen, tms, tdi, tck, int_req, switchback}), 8'h38);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    jtag_case();
    standard_case();
    @(posedge clk);
    dir <= 8'h00;
    drv_en <= 8'hFF;
    for (int p = 0; p < 8; p++) begin
      edge_case(p, 1'b0, 1'b1, p[0]);
      edge_case(p, 1'b1, 1'b1, ~p[0]);
    end
    edge_case(5, 1'b0, 1'b0, 1'b0);
    edge_case(6, 1'b1, 1'b0, 1'b0);
    gate_case();
    adc_dac_case();
    timer_case();
    end_sim();
  end
endmodule : port_ext_interrupt_and_pin_mux_bench
`default_nettype wire
